/* File: src/prs_top.sv */
// pwm restart, active-edge delay and output steering for one channel
// assumes pwm waveform, period start and port data come from logic on REF_CLK_IN;
// the shutdown condition comes from a pin and is synchronised here
//
// The register offsets and the strobed register port are this design's own decisions.
`include "prs_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module prs_top #(
  parameter int INSN_CLKS = `PRS_INSN_CLKS
) (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // register port
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // channel configuration from the mode register
  input wire logic [3:0] CHAN_MODE_IN,
  input wire logic [1:0] PWM_CFG_IN,
  // pwm source
  input wire logic PWM_RAW_IN,
  input wire logic PERIOD_START_IN,
  input wire logic SHUTDOWN_IN,
  // pins
  input wire logic [3:0] PORT_DATA_IN,
  output logic [3:0] PWM_PIN_OUT,
  output logic [3:0] PIN_STEERED_OUT,
  // status
  output logic SHUTDOWN_FLAG_OUT,
  output logic IRQ_OUT
);
  localparam int TW = (INSN_CLKS > 1) ? $clog2(INSN_CLKS) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(INSN_CLKS - 1);

  typedef struct packed {
    prs_pkg::prs_state_t state;
    logic auto_restart_enable;
    logic [6:0] active_edge_delay_count;
    logic steer_update_sync;
    prs_pkg::prs_pins_t steer_req;
    prs_pkg::prs_pins_t steer_applied;
    logic steer_pending;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    prs_pkg::prs_byte_t rdata;
    logic [TW-1:0] tick_cnt;
    prs_pkg::prs_pins_t pins;
    prs_pkg::prs_pins_t steered;
  } prs_top_st_t;

  prs_top_st_t st_q;
  prs_top_st_t st_d;

  logic shutdown_sync;
  logic pwm_delayed;
  logic insn_tick;

  // pin level for one output: pwm or its complement per polarity mode
  function automatic logic pol_level(input logic wave, input logic invert);
    pol_level = invert ? ~wave : wave;
  endfunction

  // address match for one register offset
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction

  prs_sync3 u_shut_sync (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .async_in(SHUTDOWN_IN),
    .sync_out(shutdown_sync)
  );

  prs_delay #(
    .CW(7)
  ) u_delay (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .tick_in(insn_tick),
    .count_in(st_q.active_edge_delay_count),
    .raw_in(PWM_RAW_IN),
    .dly_out(pwm_delayed)
  );

  assign insn_tick = (st_q.tick_cnt == TICK_LAST);

  always_comb begin
    logic wr_rd;
    logic wr_st;
    logic wr_sh;
    logic steer_mode;
    logic shut_now;
    logic [2:0] ev;
    prs_pkg::prs_pins_t steer_eff;
    prs_pkg::prs_pins_t inv;
    wr_rd = 1'b0;
    wr_st = 1'b0;
    wr_sh = 1'b0;
    steer_mode = 1'b0;
    shut_now = 1'b0;
    ev = 3'h0;
    steer_eff = 4'h0;
    inv = 4'h0;
    st_d = st_q;

    // instruction-cycle tick
    st_d.tick_cnt = insn_tick ? '0 : st_q.tick_cnt + 1'b1;

    wr_rd = REG_WR_IN && hit(REG_ADDR_IN, `PRS_OFS_RESTART_DELAY);
    wr_st = REG_WR_IN && hit(REG_ADDR_IN, `PRS_OFS_STEERING);
    wr_sh = REG_WR_IN && hit(REG_ADDR_IN, `PRS_OFS_SHUTDOWN);

    if (wr_rd) begin
      st_d.auto_restart_enable = REG_WDATA_IN[`PRS_BIT_RESTART_EN];
      st_d.active_edge_delay_count = REG_WDATA_IN[6:0];
    end

    // bits 7:5 are simply not stored
    if (wr_st) begin
      st_d.steer_update_sync = REG_WDATA_IN[`PRS_BIT_STEER_SYNC];
      st_d.steer_req = REG_WDATA_IN[3:0];
      st_d.steer_pending = 1'b1;
    end

    // steering update: at once, or held to a period boundary
    if (st_q.steer_pending && !wr_st) begin
      if (!st_q.steer_update_sync || PERIOD_START_IN) begin
        st_d.steer_applied = st_q.steer_req;
        st_d.steer_pending = 1'b0;
        ev[`PRS_IRQ_STEER] = 1'b1;
      end
    end

    // shutdown sequencing
    unique case (st_q.state)
      prs_pkg::PRS_RUN: begin
        if (shutdown_sync) begin
          st_d.state = prs_pkg::PRS_SHUT;
          ev[`PRS_IRQ_SHUT] = 1'b1;
        end
      end
      prs_pkg::PRS_SHUT: begin
        if (!shutdown_sync && st_q.auto_restart_enable) begin
          st_d.state = prs_pkg::PRS_RUN;
          ev[`PRS_IRQ_RESTART] = 1'b1;
        end else if (!shutdown_sync && wr_sh && !REG_WDATA_IN[`PRS_BIT_FLAG]) begin
          st_d.state = prs_pkg::PRS_RUN;
          ev[`PRS_IRQ_RESTART] = 1'b1;
        end
      end
      default: begin
        st_d.state = prs_pkg::PRS_SHUT;
      end
    endcase

    // a live condition keeps the flag set even against a software clear
    shut_now = (st_q.state == prs_pkg::PRS_SHUT);

    steer_mode = (CHAN_MODE_IN[3:2] == `PRS_STEER_MODE) &&
                 (PWM_CFG_IN == `PRS_STEER_CFG);
    steer_eff = steer_mode ? st_q.steer_applied : 4'h0;
    inv = {CHAN_MODE_IN[0], CHAN_MODE_IN[1], CHAN_MODE_IN[0], CHAN_MODE_IN[1]};

    for (int i = 0; i < 4; i++) begin
      if (steer_eff[i]) begin
        // shut down pins park at their inactive level
        st_d.pins[i] = pol_level(pwm_delayed && !shut_now, inv[i]);
      end else begin
        st_d.pins[i] = PORT_DATA_IN[i];
      end
    end
    st_d.steered = steer_eff;

    // sticky events: set wins over the write-one clear
    if (REG_WR_IN && hit(REG_ADDR_IN, `PRS_OFS_IRQ_STATUS)) begin
      st_d.irq_status = st_q.irq_status & ~REG_WDATA_IN[2:0];
    end
    st_d.irq_status = st_d.irq_status | ev;
    if (REG_WR_IN && hit(REG_ADDR_IN, `PRS_OFS_IRQ_MASK)) begin
      st_d.irq_mask = REG_WDATA_IN[2:0];
    end

    // read data stand one cycle after the strobe only
    st_d.rdata = 8'h00;
    if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        `PRS_OFS_RESTART_DELAY: begin
          st_d.rdata = {st_q.auto_restart_enable, st_q.active_edge_delay_count};
        end
        `PRS_OFS_STEERING: begin
          st_d.rdata = {3'h0, st_q.steer_update_sync, st_q.steer_req};
        end
        `PRS_OFS_SHUTDOWN: begin
          st_d.rdata = {shut_now, 3'h0, st_q.steer_applied};
        end
        `PRS_OFS_IRQ_STATUS: begin
          st_d.rdata = {5'h00, st_q.irq_status};
        end
        `PRS_OFS_IRQ_MASK: begin
          st_d.rdata = {5'h00, st_q.irq_mask};
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      st_q.state <= prs_pkg::PRS_RUN;
      st_q.auto_restart_enable <= 1'(`PRS_RST_RESTART_DELAY >> `PRS_BIT_RESTART_EN);
      st_q.active_edge_delay_count <= 7'h00;
      st_q.steer_update_sync <= 1'b0;
      st_q.steer_req <= 4'h1;
      st_q.steer_applied <= 4'h1;
      st_q.steer_pending <= 1'b0;
      st_q.irq_status <= 3'h0;
      st_q.irq_mask <= 3'h0;
      st_q.rdata <= 8'h00;
      st_q.tick_cnt <= '0;
      st_q.pins <= 4'h0;
      st_q.steered <= 4'h0;
    end else begin
      st_q <= st_d;
    end
  end

  assign REG_RDATA_OUT = st_q.rdata;
  assign PWM_PIN_OUT = st_q.pins;
  assign PIN_STEERED_OUT = st_q.steered;
  assign SHUTDOWN_FLAG_OUT = (st_q.state == prs_pkg::PRS_SHUT);
  assign IRQ_OUT = |(st_q.irq_status & st_q.irq_mask);
endmodule // prs_top

`default_nettype wire

/* File: src/prs_consts.svh */
// constants for the pwm restart, delay and steering block
// assumes a single 10 MHz clock and an 8-bit register port
// Notes on behaviour
// - restart enable set: flag clears itself once shutdown input goes away, pwm resumes.
// - restart enable clear: outputs stay shut down until software clears the flag.
// - delay count gives instruction cycles between scheduled and actual active edge.
// - steering bits 7 to 5 are unimplemented, read zero, ignore writes.
// - restart/delay register resets to zero; steering resets with output a enabled.
// - each steering enable routes polarised pwm to its pin, else port control.
// - steering acts only with mode bits 3:2 at 11 and output config at 00.
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH
// register offsets
`define PRS_OFS_RESTART_DELAY 4'h0
`define PRS_OFS_STEERING 4'h1
`define PRS_OFS_SHUTDOWN 4'h2
`define PRS_OFS_IRQ_STATUS 4'h3
`define PRS_OFS_IRQ_MASK 4'h4
// field positions
`define PRS_BIT_RESTART_EN 7
`define PRS_BIT_STEER_SYNC 4
`define PRS_BIT_FLAG 7
`define PRS_IRQ_SHUT 0
`define PRS_IRQ_RESTART 1
`define PRS_IRQ_STEER 2
// reset values and steering mode/config codes
`define PRS_RST_RESTART_DELAY 8'h00
`define PRS_RST_STEERING 5'h01
`define PRS_STEER_MODE 2'h3
`define PRS_STEER_CFG 2'h0
// timing: one instruction cycle is one oscillator period
`define PRS_CLK_PERIOD_NS 100
`define PRS_INSN_NS 100
`define PRS_INSN_CLKS ((`PRS_INSN_NS + `PRS_CLK_PERIOD_NS - 1) / `PRS_CLK_PERIOD_NS)
`endif

/* File: src/prs_pkg.sv */
// types shared by the pwm restart, delay and steering block
// assumes prs_consts.svh is included by the users
package prs_pkg;
  typedef enum logic [1:0] {
    PRS_RUN = 2'b01,
    PRS_SHUT = 2'b10
  } prs_state_t;

  typedef logic [7:0] prs_byte_t;
  typedef logic [3:0] prs_pins_t;
endpackage

/* File: src/prs_sync3.sv */
// three-stage input synchroniser with agreement filter
// assumes the input is asynchronous to clk_in
`timescale 1ns/100ps
`default_nettype none
module prs_sync3 (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // data
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic val;
  } prs_sync_st_t;

  prs_sync_st_t st_q;
  prs_sync_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // only the later stages vote; s1 may still be settling
    if (st_q.s2 == st_q.s3) begin
      st_d.val = st_q.s3;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.val;
endmodule // prs_sync3

`default_nettype wire

/* File: src/prs_delay.sv */
// active-edge delay: rising edges held back by a count of ticks
// assumes tick_in is a one-cycle pulse per instruction cycle
`timescale 1ns/100ps
`default_nettype none
module prs_delay #(
  parameter int CW = 7
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic tick_in,
  input wire logic [CW-1:0] count_in,
  // waveform
  input wire logic raw_in,
  output logic dly_out
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic prev;
    logic out;
  } prs_dly_st_t;

  prs_dly_st_t st_q;
  prs_dly_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.prev = raw_in;
    if (!raw_in) begin
      // inactive-going edge passes at once
      st_d.out = 1'b0;
      st_d.cnt = '0;
    end else if (!st_q.prev) begin
      st_d.cnt = count_in;
      st_d.out = (count_in == '0);
    end else if (!st_q.out && tick_in) begin
      st_d.cnt = st_q.cnt - 1'b1;
      st_d.out = (st_q.cnt == {{(CW-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dly_out = st_q.out;
endmodule // prs_delay

`default_nettype wire

/* File: verif/prs_stage_model.sv */
// model of the switching stage hung on the steered pins
// assumes the bench commands a fault trip; the sense path lags by two cycles
`timescale 1ns/100ps
`default_nettype none
module prs_stage_model (
  // clock
  input wire logic clk_in,
  // fault command from the bench
  input wire logic trip_in,
  // shutdown condition toward the block
  output logic fault_out
);
  // a slow current sense, so the fault never lines up with the command edge
  logic [1:0] sense_q = 2'h0;
  always_ff @(posedge clk_in) begin
    sense_q <= {sense_q[0], trip_in};
  end
  assign fault_out = sense_q[1];
endmodule // prs_stage_model
`default_nettype wire

/* File: verif/prs_top_chk.sv */
// port checker for the restart, delay and steering block
// assumes it is bound into prs_top and sees its ports only
`timescale 1ns/100ps
`default_nettype none
module prs_top_chk (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // register port
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  // channel, pins and status
  input wire logic [3:0] CHAN_MODE_IN,
  input wire logic [1:0] PWM_CFG_IN,
  input wire logic SHUTDOWN_IN,
  input wire logic [3:0] PORT_DATA_IN,
  input wire logic [3:0] PWM_PIN_OUT,
  input wire logic [3:0] PIN_STEERED_OUT,
  input wire logic SHUTDOWN_FLAG_OUT,
  input wire logic IRQ_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  // restart enable shadow, rebuilt from observed writes
  logic re_q;
  always_ff @(posedge REF_CLK_IN) begin
    re_q <= RST_IN ? 1'b0 : (REG_WR_IN && REG_ADDR_IN == 4'h0) ? REG_WDATA_IN[7] : re_q;
  end
  property p_rd_idle;
    !REG_RD_IN |=> REG_RDATA_OUT == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_steer_hi;
    REG_RD_IN && REG_ADDR_IN == 4'h1 |=> REG_RDATA_OUT[7:5] == 3'h0;
  endproperty
  a_steer_hi: assert property (p_steer_hi) else $error("steering top bits set");
  property p_rst;
    disable iff (1'b0) RST_IN |=> PIN_STEERED_OUT == 4'h0 && !SHUTDOWN_FLAG_OUT && !IRQ_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_port;
    !$past(RST_IN) |-> ((PWM_PIN_OUT ^ $past(PORT_DATA_IN)) & ~PIN_STEERED_OUT) == 4'h0;
  endproperty
  a_port: assert property (p_port) else $error("unsteered pin lost port data");
  property p_mode_off;
    CHAN_MODE_IN[3:2] != 2'h3 || PWM_CFG_IN != 2'h0
      |=> PIN_STEERED_OUT == 4'h0 && PWM_PIN_OUT == $past(PORT_DATA_IN);
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("steering outside its mode");
  property p_shut;
    SHUTDOWN_IN [*8] |-> SHUTDOWN_FLAG_OUT;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown flag not raised");
  property p_hold;
    !re_q && SHUTDOWN_FLAG_OUT && !(REG_WR_IN && REG_ADDR_IN == 4'h2) |=> SHUTDOWN_FLAG_OUT;
  endproperty
  a_hold: assert property (p_hold) else $error("flag cleared without software");
  property p_restart;
    (re_q && !SHUTDOWN_IN) [*8] |-> !SHUTDOWN_FLAG_OUT;
  endproperty
  a_restart: assert property (p_restart) else $error("auto restart missing");
  c_shut: cover property ($rose(SHUTDOWN_FLAG_OUT));
  c_irq: cover property ($rose(IRQ_OUT));
  c_sync: cover property (PIN_STEERED_OUT == 4'h1 && $past(PIN_STEERED_OUT) == 4'hF);
endmodule // prs_top_chk
bind prs_top prs_top_chk u_chk (.REF_CLK_IN, .RST_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN,
  .REG_RD_IN, .REG_RDATA_OUT, .CHAN_MODE_IN, .PWM_CFG_IN, .SHUTDOWN_IN, .PORT_DATA_IN,
  .PWM_PIN_OUT, .PIN_STEERED_OUT, .SHUTDOWN_FLAG_OUT, .IRQ_OUT);
`default_nettype wire

/* File: verif/prs_top_test.sv */
// self-checking bench for the restart, delay and steering block
// assumes prs_top, its checker and the stage model are compiled before it
`timescale 1ns/100ps
`default_nettype none
module prs_top_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [3:0] mode = 4'hC;
  logic [1:0] cfg = 2'h0;
  logic raw = 1'b0;
  logic pstart = 1'b0;
  logic trip = 1'b0;
  logic fault;
  logic [3:0] port = 4'h5;
  logic [3:0] pins;
  logic [3:0] steered;
  logic flag;
  logic irq;
  int failures = 0;
  int compares = 0;
  int l0;
  int ln;
  int dl[2] = '{5, 127};
  always #50 clk = ~clk;
  prs_top #(.INSN_CLKS(1)) uut (.REF_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .CHAN_MODE_IN(mode), .PWM_CFG_IN(cfg), .PWM_RAW_IN(raw), .PERIOD_START_IN(pstart),
    .SHUTDOWN_IN(fault), .PORT_DATA_IN(port), .PWM_PIN_OUT(pins),
    .PIN_STEERED_OUT(steered), .SHUTDOWN_FLAG_OUT(flag), .IRQ_OUT(irq));
  prs_stage_model u_stage (.clk_in(clk), .trip_in(trip), .fault_out(fault));
  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // bounded wait on the flag; running out ends the run
  task automatic wait_flag(input logic v);
    for (int i = 0; i < 50 && flag !== v; i++) cyc(1);
    chk({7'h00, flag}, {7'h00, v});
    if (flag !== v) results();
  endtask
  // cycles from a raw edge to pin a following it
  task automatic lat(input logic v, output int n);
    @(posedge clk);
    raw <= v;
    #1;
    for (n = 0; n < 300 && pins[0] !== v; n++) cyc(1);
    if (n == 300) begin
      failures++;
      $display("[ERR] %0t pin a never followed the raw edge", $time);
      results();
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_reg(4'h0, 8'h00);
    rd_reg(4'h1, 8'h01);
    rd_reg(4'hF, 8'h00);
    chk({4'h0, steered}, 8'h01);
    chk({4'h0, pins}, 8'h04);
    wr_reg(4'h1, 8'hEF);
    rd_reg(4'h1, 8'h0F);
    chk({4'h0, steered}, 8'h0F);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      mode <= {2'h3, i[1:0]};
      cyc(2);
      chk({4'h0, pins}, {4'h0, i[0], i[1], i[0], i[1]});
    end
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      mode <= j ? 4'hC : 4'h8;
      cfg <= j ? 2'h1 : 2'h0;
      cyc(2);
      chk({steered, pins}, 8'h05);
    end
    @(posedge clk);
    mode <= 4'hC;
    cfg <= 2'h0;
    wr_reg(4'h1, 8'h11);
    cyc(4);
    chk({4'h0, steered}, 8'h0F);
    @(posedge clk);
    pstart <= 1'b1;
    @(posedge clk);
    pstart <= 1'b0;
    cyc(2);
    chk({4'h0, steered}, 8'h01);
    lat(1'b1, l0);
    lat(1'b0, ln);
    foreach (dl[k]) begin
      wr_reg(4'h0, 8'(dl[k]));
      lat(1'b1, ln);
      chk(8'(ln - l0), 8'(dl[k]));
      lat(1'b0, ln);
      chk(8'(ln), 8'(l0));
    end
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h4, 8'h01);
    lat(1'b1, ln);
    @(posedge clk);
    trip <= 1'b1;
    wait_flag(1'b1);
    // pins are registered from the state, so they trail the flag by a cycle
    cyc(1);
    chk({6'h00, irq, pins[0]}, 8'h02);
    rd_reg(4'h2, 8'h81);
    @(posedge clk);
    trip <= 1'b0;
    cyc(12);
    chk({7'h00, flag}, 8'h01);
    wr_reg(4'h2, 8'h00);
    cyc(3);
    chk({7'h00, flag}, 8'h00);
    chk({7'h00, pins[0]}, 8'h01);
    wr_reg(4'h3, 8'h07);
    cyc(1);
    chk({7'h00, irq}, 8'h00);
    wr_reg(4'h4, 8'h00);
    wr_reg(4'h0, 8'h80);
    trip <= 1'b1;
    wait_flag(1'b1);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk);
    trip <= 1'b0;
    wait_flag(1'b0);
    cyc(3);
    chk({7'h00, pins[0]}, 8'h01);
    results();
  end
endmodule // prs_top_test
`default_nettype wire
